/* File: hw/mls_defines.vh */
`ifndef MLS_DEFINES_VH
`define MLS_DEFINES_VH
// clock and timing
`define MLS_CLK_HZ 250000000
`define MLS_CLK_PERIOD_NS 4
`define MLS_TICK_NS 1000000
`define MLS_TICK_CYCLES (`MLS_TICK_NS / `MLS_CLK_PERIOD_NS)
`define MLS_TIMEOUT_MAX_MS 16'hffff
// tables and instances
`define MLS_NUM_TABLES 4
`define MLS_NUM_INSTANCES 2'h3
// register offsets
`define MLS_REG_CTRL 8'h00
`define MLS_REG_SERIAL 8'h04
`define MLS_REG_TIMEOUT 8'h08
`define MLS_REG_STATION 8'h0c
`define MLS_REG_TCP_PORT 8'h10
`define MLS_REG_ALIVE 8'h14
`define MLS_REG_IRQ_STS 8'h18
`define MLS_REG_IRQ_MASK 8'h1c
// control fields
`define MLS_CTRL_ROLE 0
`define MLS_CTRL_IFACE 1
`define MLS_CTRL_PORT_LO 2
`define MLS_CTRL_PORT_HI 3
`define MLS_CTRL_VID 4
`define MLS_CTRL_IDX_LO 6
`define MLS_CTRL_IDX_HI 7
// serial fields
`define MLS_SER_BAUD_LO 0
`define MLS_SER_BAUD_HI 3
`define MLS_SER_PAR_LO 4
`define MLS_SER_PAR_HI 5
`define MLS_SER_STOP_LO 6
`define MLS_SER_STOP_HI 7
// irq fields
`define MLS_IRQ_REJECT 0
`define MLS_IRQ_SLV_EXP 1
`define MLS_IRQ_MST_EXP 2
// reset values
`define MLS_RST_CTRL 8'h40
`define MLS_RST_BAUD 4'h7
`define MLS_RST_PARITY 2'h0
`define MLS_RST_STOP 2'h1
`define MLS_RST_TIMEOUT 16'h03e8
`define MLS_RST_STATION 8'h01
`define MLS_RST_TCP_PORT 16'h0000
// encodings
`define MLS_PAR_NONE 2'h0
`define MLS_PAR_ODD 2'h1
`define MLS_PAR_EVEN 2'h2
`define MLS_TCP_DEFAULT_PORT 16'h01f6
`define MLS_VID_FIRST 16'h0079
`define MLS_VID_LAST 16'h007c
// baud rates
`define MLS_BAUD_110 110
`define MLS_BAUD_150 150
`define MLS_BAUD_300 300
`define MLS_BAUD_600 600
`define MLS_BAUD_1200 1200
`define MLS_BAUD_2400 2400
`define MLS_BAUD_4800 4800
`define MLS_BAUD_9600 9600
`define MLS_BAUD_19200 19200
`define MLS_BAUD_CODES 4'h9
`endif

/* File: hw/mls_watchdog.v */
`timescale 1ns/1ns
module mls_watchdog (
    // clock and reset
    input wire core_clk_in,
    input wire sys_rst_in,
    // control
    input wire tick_in,
    input wire [15:0] timeout_in,
    input wire restart_in,
    input wire stop_in,
    // status
    output wire running_out,
    output wire expired_out
);

reg run_q;
reg [15:0] cnt_q;
reg exp_q;

always @(posedge core_clk_in) begin
    if (sys_rst_in) begin
        run_q <= 1'b0;
        cnt_q <= 16'h0000;
        exp_q <= 1'b0;
    end else begin
        exp_q <= 1'b0;
        if (restart_in) begin
            // a restart always wins so a fresh access is never counted as late
            run_q <= 1'b1;
            cnt_q <= 16'h0000;
        end else if (stop_in) begin
            run_q <= 1'b0;
        end else if (run_q && tick_in && timeout_in != 16'h0000) begin
            if (cnt_q + 16'h0001 >= timeout_in) begin
                run_q <= 1'b0;
                exp_q <= 1'b1;
            end
            cnt_q <= cnt_q + 16'h0001;
        end
    end
end

assign running_out = run_q;
assign expired_out = exp_q;

endmodule // mls_watchdog

/* File: hw/mls_link_supervisor.v */
// Decided for this implementation: the address-and-strobe port and the address map.
`timescale 1ns/1ns
`include "mls_defines.vh"
module mls_link_supervisor #(
    parameter TICK_CYCLES = `MLS_TICK_CYCLES,
    // ident words are arbitrary values
    parameter [15:0] VID_WORD0 = 16'h1234,
    parameter [15:0] VID_WORD1 = 16'h5678,
    parameter [15:0] VID_WORD2 = 16'h9abc,
    parameter [15:0] VID_WORD3 = 16'hdef0
) (
    // clock and reset
    input wire core_clk_in,
    input wire sys_rst_in,
    // register port
    input wire [7:0] reg_addr_in,
    input wire [31:0] reg_wdata_in,
    input wire reg_wr_in,
    input wire reg_rd_in,
    output reg [31:0] reg_rdata_out,
    // frame events
    input wire [7:0] frame_addr_in,
    input wire frame_addr_valid_in,
    input wire [3:0] slave_access_in,
    input wire [3:0] master_req_end_in,
    input wire [3:0] master_reply_start_in,
    input wire [15:0] modbus_reg_offset_in,
    input wire modbus_reg_rd_in,
    // configuration outputs
    output wire role_master_out,
    output wire iface_tcp_out,
    output wire [1:0] port_instance_out,
    output wire [1:0] gateway_instance_index_out,
    output reg [21:0] baud_div_out,
    output wire [1:0] parity_out,
    output wire two_stop_out,
    output wire serial_active_out,
    output reg [15:0] tcp_listen_port_out,
    // status outputs
    output reg station_match_out,
    output wire [3:0] alive_slave_out,
    output wire [3:0] alive_master_out,
    output reg vendor_ident_hit_out,
    output reg [15:0] vendor_ident_data_out,
    output wire irq_out
);

////////////////////////////////////////////////////////////////////////////////
// configuration registers

reg role_q;
reg iface_q;
reg [1:0] port_q;
reg vid_q;
reg [1:0] idx_q;
reg [3:0] baud_q;
reg [1:0] parity_q;
reg [1:0] stop_q;
reg [15:0] timeout_q;
reg [7:0] station_q;
reg [15:0] tcp_port_q;
reg [2:0] irq_sts_q;
reg [2:0] irq_mask_q;
reg [3:0] alive_s_q;
reg [3:0] alive_m_q;
reg [17:0] tick_cnt_q;
reg tick_q;

// reset image of the control register, split per field below
localparam [7:0] RST_CTRL = `MLS_RST_CTRL;

wire wr_ctrl = reg_wr_in && reg_addr_in == `MLS_REG_CTRL;
wire wr_ser = reg_wr_in && reg_addr_in == `MLS_REG_SERIAL;
wire wr_to = reg_wr_in && reg_addr_in == `MLS_REG_TIMEOUT;
wire wr_stn = reg_wr_in && reg_addr_in == `MLS_REG_STATION;
wire wr_tcp = reg_wr_in && reg_addr_in == `MLS_REG_TCP_PORT;
wire wr_sts = reg_wr_in && reg_addr_in == `MLS_REG_IRQ_STS;
wire wr_msk = reg_wr_in && reg_addr_in == `MLS_REG_IRQ_MASK;

wire [1:0] new_idx = reg_wdata_in[`MLS_CTRL_IDX_HI:`MLS_CTRL_IDX_LO];
wire [3:0] new_baud = reg_wdata_in[`MLS_SER_BAUD_HI:`MLS_SER_BAUD_LO];
wire [1:0] new_par = reg_wdata_in[`MLS_SER_PAR_HI:`MLS_SER_PAR_LO];
wire [1:0] new_stop = reg_wdata_in[`MLS_SER_STOP_HI:`MLS_SER_STOP_LO];

wire idx_ok = new_idx != 2'h0 && new_idx <= `MLS_NUM_INSTANCES;
wire baud_ok = new_baud < `MLS_BAUD_CODES;
wire par_ok = new_par == `MLS_PAR_NONE || new_par == `MLS_PAR_ODD ||
    new_par == `MLS_PAR_EVEN;
wire stop_ok = new_stop == 2'h1 || new_stop == 2'h2;
wire stn_ok = reg_wdata_in[7:0] != 8'h00;

// a bad field is dropped alone; the other fields of the same write still land
wire reject_ev = (wr_ctrl && !idx_ok) ||
    (wr_ser && !(baud_ok && par_ok && stop_ok)) || (wr_stn && !stn_ok);

always @(posedge core_clk_in) begin
    if (sys_rst_in) begin
        role_q <= RST_CTRL[`MLS_CTRL_ROLE];
        iface_q <= RST_CTRL[`MLS_CTRL_IFACE];
        port_q <= RST_CTRL[`MLS_CTRL_PORT_HI:`MLS_CTRL_PORT_LO];
        vid_q <= RST_CTRL[`MLS_CTRL_VID];
        idx_q <= RST_CTRL[`MLS_CTRL_IDX_HI:`MLS_CTRL_IDX_LO];
        baud_q <= `MLS_RST_BAUD;
        parity_q <= `MLS_RST_PARITY;
        stop_q <= `MLS_RST_STOP;
        timeout_q <= `MLS_RST_TIMEOUT;
        station_q <= `MLS_RST_STATION;
        tcp_port_q <= `MLS_RST_TCP_PORT;
        irq_mask_q <= 3'h0;
    end else begin
        if (wr_ctrl) begin
            role_q <= reg_wdata_in[`MLS_CTRL_ROLE];
            iface_q <= reg_wdata_in[`MLS_CTRL_IFACE];
            port_q <= reg_wdata_in[`MLS_CTRL_PORT_HI:`MLS_CTRL_PORT_LO];
            vid_q <= reg_wdata_in[`MLS_CTRL_VID];
            if (idx_ok) begin
                idx_q <= new_idx;
            end
        end
        if (wr_ser) begin
            if (baud_ok) begin
                baud_q <= new_baud;
            end
            if (par_ok) begin
                parity_q <= new_par;
            end
            if (stop_ok) begin
                stop_q <= new_stop;
            end
        end
        if (wr_to) begin
            timeout_q <= reg_wdata_in[15:0];
        end
        if (wr_stn && stn_ok) begin
            station_q <= reg_wdata_in[7:0];
        end
        if (wr_tcp) begin
            tcp_port_q <= reg_wdata_in[15:0];
        end
        if (wr_msk) begin
            irq_mask_q <= reg_wdata_in[2:0];
        end
    end
end

////////////////////////////////////////////////////////////////////////////////
// derived link settings

wire slave_role = !role_q;
wire serial_if = !iface_q;

// divisors are worked out at 32 bits; the slowest rate needs only 22 of them
localparam [31:0] DIV_110 = `MLS_CLK_HZ / `MLS_BAUD_110;
localparam [31:0] DIV_150 = `MLS_CLK_HZ / `MLS_BAUD_150;
localparam [31:0] DIV_300 = `MLS_CLK_HZ / `MLS_BAUD_300;
localparam [31:0] DIV_600 = `MLS_CLK_HZ / `MLS_BAUD_600;
localparam [31:0] DIV_1200 = `MLS_CLK_HZ / `MLS_BAUD_1200;
localparam [31:0] DIV_2400 = `MLS_CLK_HZ / `MLS_BAUD_2400;
localparam [31:0] DIV_4800 = `MLS_CLK_HZ / `MLS_BAUD_4800;
localparam [31:0] DIV_9600 = `MLS_CLK_HZ / `MLS_BAUD_9600;
localparam [31:0] DIV_19200 = `MLS_CLK_HZ / `MLS_BAUD_19200;

assign role_master_out = role_q;
assign iface_tcp_out = iface_q;
assign port_instance_out = port_q;
assign gateway_instance_index_out = idx_q;
assign serial_active_out = serial_if;
assign parity_out = serial_if ? parity_q : `MLS_PAR_NONE;
assign two_stop_out = serial_if && stop_q == 2'h2;

always @(posedge core_clk_in) begin
    if (sys_rst_in) begin
        baud_div_out <= 22'h000000;
        tcp_listen_port_out <= 16'h0000;
    end else begin
        if (!serial_if) begin
            baud_div_out <= 22'h000000;
        end else begin
            case (baud_q)
                4'h0: baud_div_out <= DIV_110[21:0];
                4'h1: baud_div_out <= DIV_150[21:0];
                4'h2: baud_div_out <= DIV_300[21:0];
                4'h3: baud_div_out <= DIV_600[21:0];
                4'h4: baud_div_out <= DIV_1200[21:0];
                4'h5: baud_div_out <= DIV_2400[21:0];
                4'h6: baud_div_out <= DIV_4800[21:0];
                4'h7: baud_div_out <= DIV_9600[21:0];
                default: baud_div_out <= DIV_19200[21:0];
            endcase
        end
        if (iface_q && slave_role) begin
            tcp_listen_port_out <= (tcp_port_q == 16'h0000) ?
                `MLS_TCP_DEFAULT_PORT : tcp_port_q;
        end else begin
            tcp_listen_port_out <= 16'h0000;
        end
    end
end

////////////////////////////////////////////////////////////////////////////////
// station address and vendor ident

always @(posedge core_clk_in) begin
    if (sys_rst_in) begin
        station_match_out <= 1'b0;
        vendor_ident_hit_out <= 1'b0;
        vendor_ident_data_out <= 16'h0000;
    end else begin
        station_match_out <= frame_addr_valid_in && slave_role &&
            frame_addr_in == station_q;
        vendor_ident_hit_out <= 1'b0;
        vendor_ident_data_out <= 16'h0000;
        if (modbus_reg_rd_in && vid_q && slave_role &&
            modbus_reg_offset_in >= `MLS_VID_FIRST &&
            modbus_reg_offset_in <= `MLS_VID_LAST) begin
            vendor_ident_hit_out <= 1'b1;
            case (modbus_reg_offset_in[1:0])
                2'h1: vendor_ident_data_out <= VID_WORD0;
                2'h2: vendor_ident_data_out <= VID_WORD1;
                2'h3: vendor_ident_data_out <= VID_WORD2;
                default: vendor_ident_data_out <= VID_WORD3;
            endcase
        end
    end
end

////////////////////////////////////////////////////////////////////////////////
// millisecond tick and table watchdogs

always @(posedge core_clk_in) begin
    if (sys_rst_in) begin
        tick_cnt_q <= 18'h00000;
        tick_q <= 1'b0;
    end else if (tick_cnt_q == TICK_CYCLES - 1) begin
        tick_cnt_q <= 18'h00000;
        tick_q <= 1'b1;
    end else begin
        tick_cnt_q <= tick_cnt_q + 18'h00001;
        tick_q <= 1'b0;
    end
end

wire [3:0] s_access = slave_access_in & {4{slave_role}};
wire [3:0] m_req = master_req_end_in & {4{role_q}};
wire [3:0] m_reply = master_reply_start_in & {4{role_q}};
wire [3:0] s_exp;
wire [3:0] m_exp;
wire [3:0] m_run;

genvar gi;
generate
    for (gi = 0; gi < `MLS_NUM_TABLES; gi = gi + 1) begin : g_tab
        mls_watchdog u_slv_wd (
            .core_clk_in(core_clk_in),
            .sys_rst_in(sys_rst_in),
            .tick_in(tick_q),
            .timeout_in(timeout_q),
            .restart_in(s_access[gi]),
            .stop_in(role_q),
            .running_out(),
            .expired_out(s_exp[gi])
        );
        mls_watchdog u_mst_wd (
            .core_clk_in(core_clk_in),
            .sys_rst_in(sys_rst_in),
            .tick_in(tick_q),
            .timeout_in(timeout_q),
            .restart_in(m_req[gi]),
            .stop_in(m_reply[gi] || slave_role),
            .running_out(m_run[gi]),
            .expired_out(m_exp[gi])
        );
    end
endgenerate

// a fresh slave access beats an expiry in the same cycle; a master reply only counts while its watchdog runs
wire [3:0] alive_s_d = (alive_s_q & ~s_exp) | s_access;
wire [3:0] alive_m_d = (alive_m_q & ~m_exp) | (m_reply & m_run);

always @(posedge core_clk_in) begin
    if (sys_rst_in) begin
        alive_s_q <= 4'h0;
        alive_m_q <= 4'h0;
    end else begin
        alive_s_q <= alive_s_d;
        alive_m_q <= alive_m_d;
    end
end

assign alive_slave_out = alive_s_q;
assign alive_master_out = alive_m_q;

////////////////////////////////////////////////////////////////////////////////
// interrupts and read port

wire [2:0] irq_ev = {|m_exp, |s_exp, reject_ev};
wire [2:0] irq_clr = wr_sts ? reg_wdata_in[2:0] : 3'h0;

always @(posedge core_clk_in) begin
    if (sys_rst_in) begin
        irq_sts_q <= 3'h0;
    end else begin
        irq_sts_q <= (irq_sts_q & ~irq_clr) | irq_ev;
    end
end

assign irq_out = |(irq_sts_q & irq_mask_q);

always @(posedge core_clk_in) begin
    if (sys_rst_in) begin
        reg_rdata_out <= 32'h00000000;
    end else if (!reg_rd_in) begin
        reg_rdata_out <= 32'h00000000;
    end else if (reg_addr_in == `MLS_REG_CTRL) begin
        reg_rdata_out <= {24'h000000, idx_q, 1'b0, vid_q, port_q, iface_q, role_q};
    end else if (reg_addr_in == `MLS_REG_SERIAL) begin
        reg_rdata_out <= {24'h000000, stop_q, parity_q, baud_q};
    end else if (reg_addr_in == `MLS_REG_TIMEOUT) begin
        reg_rdata_out <= {16'h0000, timeout_q};
    end else if (reg_addr_in == `MLS_REG_STATION) begin
        reg_rdata_out <= {24'h000000, station_q};
    end else if (reg_addr_in == `MLS_REG_TCP_PORT) begin
        reg_rdata_out <= {16'h0000, tcp_port_q};
    end else if (reg_addr_in == `MLS_REG_ALIVE) begin
        reg_rdata_out <= {24'h000000, alive_m_q, alive_s_q};
    end else if (reg_addr_in == `MLS_REG_IRQ_STS) begin
        reg_rdata_out <= {29'h00000000, irq_sts_q};
    end else if (reg_addr_in == `MLS_REG_IRQ_MASK) begin
        reg_rdata_out <= {29'h00000000, irq_mask_q};
    end else begin
        reg_rdata_out <= 32'h00000000;
    end
end

endmodule // mls_link_supervisor

/* File: sim/mls_link_supervisor_assertions.sv */
`timescale 1ns/1ns
module mls_chk (
    // clock and reset
    input wire core_clk_in,
    input wire sys_rst_in,
    // watched ports
    input wire reg_wr_in,
    input wire frame_addr_valid_in,
    input wire [3:0] slave_access_in,
    input wire [15:0] modbus_reg_offset_in,
    input wire modbus_reg_rd_in,
    input wire role_master_out,
    input wire iface_tcp_out,
    input wire [1:0] gateway_instance_index_out,
    input wire [21:0] baud_div_out,
    input wire [1:0] parity_out,
    input wire two_stop_out,
    input wire [15:0] tcp_listen_port_out,
    input wire station_match_out,
    input wire [3:0] alive_slave_out,
    input wire vendor_ident_hit_out
);
default clocking cb @(posedge core_clk_in); endclocking
default disable iff (sys_rst_in);
////////////////////////////////////////////////////////////
AST_STN: assert property (station_match_out |->
    $past(frame_addr_valid_in) && !$past(role_master_out)) else $error("stray match");
AST_IDX: assert property (gateway_instance_index_out != 2'h0)
    else $error("index zero");
AST_PAR: assert property (parity_out != 2'h3) else $error("bad parity");
AST_TCPF: assert property (iface_tcp_out |-> parity_out == 2'h0 && !two_stop_out)
    else $error("serial framing in tcp");
// derived outputs lag a config change by one edge, so only steady config is judged
AST_PORT: assert property (
    !$past(sys_rst_in) && $stable({iface_tcp_out, role_master_out}) && iface_tcp_out
    && !role_master_out |-> tcp_listen_port_out != 16'h0000) else $error("port zero");
AST_BAUD: assert property (
    !$past(sys_rst_in) && $stable(iface_tcp_out) && !iface_tcp_out
    |-> baud_div_out >= 22'h0032dc && baud_div_out <= 22'h22add8) else $error("bad baud");
AST_VID: assert property (vendor_ident_hit_out |-> $past(modbus_reg_rd_in) &&
    $past(modbus_reg_offset_in) inside {[16'h0079:16'h007c]}) else $error("stray ident");
AST_SACC: assert property (
    !role_master_out && !reg_wr_in && slave_access_in[0] |=> alive_slave_out[0])
    else $error("access missed");
AST_SIGN: assert property (role_master_out && $past(role_master_out) |->
    (alive_slave_out & ~$past(alive_slave_out)) == 4'h0) else $error("slave alive rose");
COV_STN: cover property (station_match_out);
COV_VID: cover property (vendor_ident_hit_out);
COV_EXP: cover property ($fell(alive_slave_out[0]));
endmodule // mls_chk
bind mls_link_supervisor mls_chk mls_chk_inst (.core_clk_in, .sys_rst_in, .reg_wr_in,
    .frame_addr_valid_in, .slave_access_in, .modbus_reg_offset_in, .modbus_reg_rd_in,
    .role_master_out, .iface_tcp_out, .gateway_instance_index_out, .baud_div_out,
    .parity_out, .two_stop_out, .tcp_listen_port_out, .station_match_out,
    .alive_slave_out, .vendor_ident_hit_out);

/* File: sim/mls_peer.sv */
`timescale 1ns/1ns
module mls_peer (
    // clock and reset
    input wire core_clk_in,
    input wire sys_rst_in,
    // bench control
    input wire go_in,
    input wire mst_in,
    input wire [1:0] tbl_in,
    input wire [7:0] addr_in,
    input wire [7:0] gap_in,
    output wire busy_out,
    // frame events
    output reg [7:0] fa_out = 8'h00,
    output reg fv_out = 1'b0,
    output reg [3:0] acc_out = 4'h0,
    output reg [3:0] req_out = 4'h0,
    output reg [3:0] rep_out = 4'h0
);
reg act_q = 1'b0;
reg mst_q = 1'b0;
reg [1:0] tbl_q = 2'h0;
reg [7:0] cnt_q = 8'h00;
assign busy_out = act_q;
////////////////////////////////////////////////////////////
always @(posedge core_clk_in) begin
    fv_out <= 1'b0;
    acc_out <= 4'h0;
    req_out <= 4'h0;
    rep_out <= 4'h0;
    // idle address wanders so a stale value cannot match by luck
    fa_out <= ~fa_out;
    if (sys_rst_in) begin
        act_q <= 1'b0;
    end else if (go_in) begin
        act_q <= 1'b1;
        mst_q <= mst_in;
        tbl_q <= tbl_in;
        cnt_q <= gap_in;
        if (mst_in) req_out[tbl_in] <= 1'b1;
        else begin
            fa_out <= addr_in;
            fv_out <= 1'b1;
        end
    end else if (act_q) begin
        cnt_q <= cnt_q - 8'h01;
        if (cnt_q == 8'h00) begin
            act_q <= 1'b0;
            if (mst_q) rep_out[tbl_q] <= 1'b1;
            else acc_out[tbl_q] <= 1'b1;
        end
    end
end
endmodule // mls_peer

/* File: sim/tb_mls_link_supervisor.sv */
`timescale 1ns/1ns
module tb_mls_link_supervisor;
reg core_clk_in = 1'b0;
reg sys_rst_in = 1'b1;
reg [7:0] reg_addr_in = 8'h00;
reg [31:0] reg_wdata_in = 32'h0;
reg reg_wr_in = 1'b0;
reg reg_rd_in = 1'b0;
reg [15:0] modbus_reg_offset_in = 16'h0;
reg modbus_reg_rd_in = 1'b0;
reg go = 1'b0;
reg pm = 1'b0;
reg [1:0] pt = 2'h0;
reg [7:0] pa = 8'h00;
reg [7:0] pg = 8'h00;
wire [31:0] reg_rdata_out;
wire [7:0] frame_addr_in;
wire frame_addr_valid_in, role_master_out, iface_tcp_out, two_stop_out;
wire station_match_out, vendor_ident_hit_out, irq_out, pbusy, serial_active_out;
wire [3:0] slave_access_in, master_req_end_in, master_reply_start_in;
wire [3:0] alive_slave_out, alive_master_out;
wire [1:0] gateway_instance_index_out, parity_out, port_instance_out;
wire [21:0] baud_div_out;
wire [15:0] tcp_listen_port_out, vendor_ident_data_out;
integer err_count = 0;
integer checks_done = 0;
integer cyc = 0;
integer hits = 0;
integer i, r, d;
localparam [143:0] RATES = {16'h4b00, 16'h2580, 16'h12c0, 16'h0960, 16'h04b0,
    16'h0258, 16'h012c, 16'h0096, 16'h006e};
localparam [63:0] VIDW = {16'hdef0, 16'h9abc, 16'h5678, 16'h1234};
localparam [31:0] SW = {8'hd7, 8'h17, 8'ha7, 8'h77};
localparam [31:0] SE = {8'h97, 8'h97, 8'ha7, 8'h47};
// short tick keeps every time-out about twenty cycles
mls_link_supervisor #(.TICK_CYCLES(4)) mls_link_supervisor_inst (.core_clk_in, .sys_rst_in,
    .reg_addr_in, .reg_wdata_in, .reg_wr_in, .reg_rd_in, .reg_rdata_out, .frame_addr_in,
    .frame_addr_valid_in, .slave_access_in, .master_req_end_in, .master_reply_start_in,
    .modbus_reg_offset_in, .modbus_reg_rd_in, .role_master_out, .iface_tcp_out,
    .port_instance_out, .gateway_instance_index_out, .baud_div_out, .parity_out,
    .two_stop_out, .serial_active_out, .tcp_listen_port_out, .station_match_out,
    .alive_slave_out, .alive_master_out, .vendor_ident_hit_out, .vendor_ident_data_out,
    .irq_out);
mls_peer mls_peer_inst (.core_clk_in, .sys_rst_in, .go_in(go), .mst_in(pm), .tbl_in(pt),
    .addr_in(pa), .gap_in(pg), .busy_out(pbusy), .fa_out(frame_addr_in),
    .fv_out(frame_addr_valid_in), .acc_out(slave_access_in), .req_out(master_req_end_in),
    .rep_out(master_reply_start_in));
////////////////////////////////////////////////////////////
always #2 core_clk_in = ~core_clk_in;
task conclude;
    begin
        $display("checks %0d mismatches %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    end
endtask
always @(posedge core_clk_in) begin
    cyc = cyc + 1;
    if (station_match_out === 1'b1) hits = hits + 1;
    if (cyc == 20000) begin
        err_count = err_count + 1;
        conclude;
    end
end
task ck(input [31:0] g, input [31:0] e);
    begin
        checks_done = checks_done + 1;
        if (g !== e) begin
            err_count = err_count + 1;
            $display("BAD t=%0t got=%h exp=%h", $time, g, e);
        end
    end
endtask
task cy(input integer n);
    begin
        repeat (n) @(posedge core_clk_in);
        #1;
    end
endtask
task wr(input [7:0] a, input [31:0] v);
    begin
        reg_addr_in <= a;
        reg_wdata_in <= v;
        reg_wr_in <= 1'b1;
        @(posedge core_clk_in);
        reg_wr_in <= 1'b0;
        cy(1);
    end
endtask
task rd(input [7:0] a, input [31:0] e);
    begin
        reg_addr_in <= a;
        reg_rd_in <= 1'b1;
        @(posedge core_clk_in);
        reg_rd_in <= 1'b0;
        #1;
        ck(reg_rdata_out, e);
        cy(1);
    end
endtask
task mb(input [15:0] o);
    begin
        modbus_reg_offset_in <= o;
        modbus_reg_rd_in <= 1'b1;
        @(posedge core_clk_in);
        modbus_reg_rd_in <= 1'b0;
        #1;
    end
endtask
task pr(input m, input [1:0] t, input [7:0] a, input [7:0] g);
    begin
        pm <= m;
        pt <= t;
        pa <= a;
        pg <= g;
        go <= 1'b1;
        @(posedge core_clk_in);
        go <= 1'b0;
        cy(1);
        while (pbusy === 1'b1) cy(1);
        cy(2);
    end
endtask
////////////////////////////////////////////////////////////
initial begin
    cy(12);
    sys_rst_in <= 1'b0;
    cy(1);
    rd(8'h00, 32'h40);
    rd(8'h04, 32'h47);
    rd(8'h08, 32'h3e8);
    rd(8'h20, 32'h0);
    $display("reset test end");
    for (i = 0; i < 9; i = i + 1) begin
        wr(8'h04, 32'h40 | i);
        r = RATES[i*16 +: 16];
        d = baud_div_out * r - 250000000;
        ck(d < r && d > -r, 1);
    end
    wr(8'h04, 32'h49);
    rd(8'h04, 32'h48);
    for (i = 0; i < 4; i = i + 1) begin
        wr(8'h04, SW[i*8 +: 8]);
        rd(8'h04, SE[i*8 +: 8]);
    end
    ck({parity_out, two_stop_out}, 3'h3);
    rd(8'h18, 32'h1);
    wr(8'h18, 32'h1);
    $display("serial test end");
    wr(8'h00, 32'h0);
    rd(8'h00, 32'h40);
    wr(8'h00, 32'hc0);
    ck(gateway_instance_index_out, 2'h3);
    wr(8'h08, 32'hffff);
    rd(8'h08, 32'hffff);
    wr(8'h08, 32'h5);
    wr(8'h0c, 32'h0);
    rd(8'h0c, 32'h1);
    wr(8'h0c, 32'h42);
    wr(8'h1c, 32'h6);
    hits = 0;
    pr(0, 0, 8'h42, 0);
    pr(0, 0, 8'h43, 0);
    ck(hits, 1);
    ck(alive_slave_out, 4'h1);
    cy(10);
    pr(0, 0, 8'h42, 0);
    cy(13);
    ck(alive_slave_out, 4'h1);
    cy(10);
    ck(alive_slave_out, 4'h0);
    ck(irq_out, 1'b1);
    // reject bit still set from the refused index and station writes
    rd(8'h18, 32'h3);
    wr(8'h18, 32'h3);
    ck(irq_out, 1'b0);
    $display("slave test end");
    wr(8'h00, 32'h4e);
    ck({role_master_out, iface_tcp_out, serial_active_out, port_instance_out}, 5'h0b);
    ck(tcp_listen_port_out, 16'h01f6);
    ck(parity_out, 2'h0);
    wr(8'h10, 32'h1234);
    ck(tcp_listen_port_out, 16'h1234);
    wr(8'h00, 32'h43);
    ck(tcp_listen_port_out, 16'h0);
    wr(8'h00, 32'h40);
    mb(16'h0079);
    ck(vendor_ident_hit_out, 1'b0);
    wr(8'h00, 32'h50);
    for (i = 120; i < 126; i = i + 1) begin
        mb(i);
        if (i > 120 && i < 125)
            ck({vendor_ident_hit_out, vendor_ident_data_out},
                {1'b1, VIDW[(i-121)*16 +: 16]});
        else ck(vendor_ident_hit_out, 1'b0);
    end
    $display("tcp and ident test end");
    wr(8'h00, 32'h41);
    pr(1, 2, 8'h00, 3);
    rd(8'h14, 32'h40);
    pr(1, 2, 8'h00, 40);
    ck(alive_master_out, 4'h0);
    rd(8'h18, 32'h4);
    ck(irq_out, 1'b1);
    pr(0, 1, 8'h42, 0);
    ck(alive_slave_out, 4'h0);
    $display("master test end");
    conclude;
end
endmodule // tb_mls_link_supervisor
